/* File: dv/general_purpose_io_ports_test.sv */
`timescale 1ns/1ps

module general_purpose_io_ports_test;
    logic        clk;
    logic        reset_n;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr_s;
    logic        rd_s;
    logic [31:0] rdata;
    logic [3:0]  irq;
    logic [31:0] ext_v [4];
    logic [31:0] ext_e [4];
    logic [31:0] alt_o [4];
    logic [31:0] alt_e [4];
    wire  [31:0] po [4];
    wire  [31:0] poe [4];
    wire  [31:0] asel [4];
    wire  [31:0] ain [4];
    wire  [31:0] lv [4];
    int          mismatches;
    int          tests_run;

    always #20 clk = ~clk;

    gpio_ports dut (
        .clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr_s), .rd_i(rd_s), .rdata_o(rdata), .irq_o(irq),
        .a_pin_i(lv[0][31:0]), .a_pin_o(po[0][31:0]), .a_pin_oe_n_o(poe[0][31:0]),
        .a_alt_sel_o(asel[0][31:0]), .a_alt_in_o(ain[0][31:0]),
        .a_alt_out_i(alt_o[0][31:0]), .a_alt_oe_i(alt_e[0][31:0]),
        .b_pin_i(lv[1][31:0]), .b_pin_o(po[1][31:0]), .b_pin_oe_n_o(poe[1][31:0]),
        .b_alt_sel_o(asel[1][31:0]), .b_alt_in_o(ain[1][31:0]),
        .b_alt_out_i(alt_o[1][31:0]), .b_alt_oe_i(alt_e[1][31:0]),
        .c_pin_i(lv[2][23:0]), .c_pin_o(po[2][23:0]), .c_pin_oe_n_o(poe[2][23:0]),
        .c_alt_sel_o(asel[2][23:0]), .c_alt_in_o(ain[2][23:0]),
        .c_alt_out_i(alt_o[2][23:0]), .c_alt_oe_i(alt_e[2][23:0]),
        .d_pin_i(lv[3][15:0]), .d_pin_o(po[3][15:0]), .d_pin_oe_n_o(poe[3][15:0]),
        .d_alt_sel_o(asel[3][15:0]), .d_alt_in_o(ain[3][15:0]),
        .d_alt_out_i(alt_o[3][15:0]), .d_alt_oe_i(alt_e[3][15:0])
    );

    for (genvar g = 0; g < 4; g++) begin : pads
        localparam int PW = (g == 2) ? 24 : ((g == 3) ? 16 : 32);
        if (PW < 32) begin : hi
            assign {po[g][31:PW], poe[g][31:PW]} = '0;
            assign {asel[g][31:PW], ain[g][31:PW]} = '0;
        end
        pin_model #(.W(PW)) u_pad (
            .clk_i(clk), .drv_i(po[g][PW-1:0]), .oe_n_i(poe[g][PW-1:0]),
            .ext_i(ext_v[g][PW-1:0]), .ext_en_i(ext_e[g][PW-1:0]),
            .level_o(lv[g][PW-1:0])
        );
    end

    // ======================================================================
    // Helpers
    function automatic logic [31:0] msk(int p);
        return (p == 2) ? 32'h00FFFFFF : ((p == 3) ? 32'h0000FFFF : 32'hFFFFFFFF);
    endfunction : msk

    function automatic logic [11:0] rg(int p, int ofs);
        return 12'((p << 8) + ofs);
    endfunction : rg

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge clk);
        wr_s  <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic set_line(input int p, input int l, input logic v);
        @(posedge clk);
        ext_v[p][l] <= v;
    endtask : set_line

    task automatic irq_case(input int p, input int l, input logic e, input logic pl);
        logic [31:0] b;
        b = 32'h1 << l;
        set_line(p, l, ~pl);
        settle(4);
        wr(rg(p, 8'h10), pl ? b : 32'h0);
        wr(rg(p, 8'h14), e ? b : 32'h0);
        wr(rg(p, 8'h0C), b);
        wr(rg(p, 8'h00), b);
        settle(4);
        check("irq idle", {31'h0, irq[p]}, 32'h0);
        set_line(p, l, pl);
        settle(4);
        check("irq active", {31'h0, irq[p]}, 32'h1);
        set_line(p, l, ~pl);
        settle(4);
        check("irq after", {31'h0, irq[p]}, {31'h0, e});
        wr(rg(p, 8'h00), b);
        settle(2);
        check("irq cleared", {31'h0, irq[p]}, 32'h0);
        wr(rg(p, 8'h0C), 32'h0);
        set_line(p, l, pl);
        settle(4);
        check("irq masked", {31'h0, irq[p]}, 32'h0);
    endtask : irq_case

    // ======================================================================
    // Main sequence
    initial begin
        logic [31:0] d, o, al, v, q, k, w;
        clk = 1'b0;
        reset_n = 1'b0;
        addr = '0;
        wdata = '0;
        wr_s = 1'b0;
        rd_s = 1'b0;
        mismatches = 0;
        tests_run = 0;
        for (int p = 0; p < 4; p++) begin
            ext_v[p] = '0;
            ext_e[p] = '1;
            alt_o[p] = '0;
            alt_e[p] = '0;
        end
        void'($urandom(32'h0525bcf1));
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int p = 0; p < 4; p++) begin
            check("oe_n reset", poe[p], msk(p));
            for (int r = 0; r < 7; r++) begin
                rd(rg(p, r * 4), q);
                check("reg reset", q, 32'h0);
            end
            for (int r = 1; r < 7; r++) begin
                repeat (2) begin
                    d = $urandom();
                    wr(rg(p, r * 4), d);
                    rd(rg(p, r * 4), q);
                    check("reg rw", q, d & msk(p));
                end
                wr(rg(p, r * 4), 32'h0);
            end
        end
        wr(12'h408, 32'hFFFFFFFF);
        rd(12'h008, q);
        check("alias write", q, 32'h0);
        rd(12'h01C, q);
        check("unmapped", q, 32'h0);
        rd(12'h405, q);
        check("unmapped", q, 32'h0);
        for (int p = 0; p < 4; p++) begin
            repeat (4) begin
                d = $urandom();
                o = $urandom();
                al = $urandom();
                @(posedge clk);
                alt_o[p] <= $urandom();
                alt_e[p] <= $urandom();
                ext_e[p] <= $urandom();
                wr(rg(p, 8'h08), d);
                wr(rg(p, 8'h04), o);
                wr(rg(p, 8'h18), al);
                settle(1);
                check("alt sel", asel[p], al & msk(p));
                check("pin out", po[p], ((al & alt_o[p]) | (~al & o)) & msk(p));
                check("pin oe_n", poe[p], ((al & ~alt_e[p]) | (~al & ~d)) & msk(p));
                // Driven lines loop back; released lines show the outside driver
                k = (al & alt_e[p]) | (~al & d);
                v = (al & alt_o[p]) | (~al & o);
                w = (k | ext_e[p]) & msk(p);
                rd(rg(p, 8'h00), q);
                check("pin loop", q & w, ((k & v) | (~k & ext_v[p])) & w);
            end
            @(posedge clk);
            ext_e[p] <= '1;
            wr(rg(p, 8'h08), 32'h0);
            wr(rg(p, 8'h18), 32'h0);
            repeat (3) begin
                v = $urandom();
                q = ext_v[p];
                @(posedge clk);
                ext_v[p] <= v;
                settle(1);
                check("sync stage", ain[p], q & msk(p));
                settle(1);
                check("sync out", ain[p], v & msk(p));
                rd(rg(p, 8'h00), q);
                check("pin input", q, v & msk(p));
            end
        end
        for (int m = 0; m < 4; m++) begin
            for (int p = 0; p < 4; p++) begin
                irq_case(p, $urandom_range((p == 2) ? 23 : ((p == 3) ? 15 : 31), 0),
                         m[1], m[0]);
            end
        end
        end_of_test();
    end

    initial begin
        repeat (100000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
endmodule : general_purpose_io_ports_test

/* File: dv/pin_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Pad wire: device drive wins, else the outside driver, else a churning line
module pin_model #(
    parameter int W = 32
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_n_i,
    input  wire logic [W-1:0] ext_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] level_o
);
    logic [W-1:0] churn_r;

    initial churn_r = '0;
    // Undriven lines change every cycle so a stale value never passes
    always @(posedge clk_i) churn_r <= ~churn_r;

    assign level_o = (~oe_n_i & drv_i) | (oe_n_i & ext_en_i & ext_i)
                   | (oe_n_i & ~ext_en_i & churn_r);
endmodule : pin_model

/* File: verilog/gpio_cfg.svh */
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ==========================================================================
// Port bases, spaced 0x100 apart
`define PORT_A_BASE        12'h000
`define PORT_STRIDE_SHIFT  8
`define PORT_COUNT         4

// ==========================================================================
// Register offsets within a port
`define OFS_PIN_INPUT      8'h00
`define OFS_PIN_OUTPUT     8'h04
`define OFS_DIRECTION      8'h08
`define OFS_IRQ_ENABLE     8'h0C
`define OFS_POLARITY       8'h10
`define OFS_EDGE_SELECT    8'h14
`define OFS_ALT_FUNCTION   8'h18

// ==========================================================================
// Reset values and widths
`define REG_RESET          32'h0000_0000
`define WIDTH_PORT_A       32
`define WIDTH_PORT_B       32
`define WIDTH_PORT_C       24
`define WIDTH_PORT_D       16
`define SYNC_STAGES        2

`endif

/* File: verilog/gpio_pkg.sv */
package gpio_pkg;

    // Register selected inside one port
    typedef enum logic [2:0] {
        SEL_INPUT,
        SEL_OUTPUT,
        SEL_DIRECTION,
        SEL_IRQ_ENABLE,
        SEL_POLARITY,
        SEL_EDGE,
        SEL_ALT,
        SEL_NONE
    } reg_sel_t;

endpackage : gpio_pkg

/* File: verilog/gpio_port.sv */
`timescale 1ns/1ps
`include "gpio_cfg.svh"

module gpio_port #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    // Register access
    input  wire logic              wr_i,
    input  wire gpio_pkg::reg_sel_t sel_i,
    input  wire logic [31:0]       wdata_i,
    output logic      [31:0]       rdata_o,
    // Pins and alternate function
    input  wire logic [WIDTH-1:0]  pin_in_i,
    output logic      [WIDTH-1:0]  pin_out_o,
    output logic      [WIDTH-1:0]  pin_oe_n_o,
    output logic      [WIDTH-1:0]  alt_sel_o,
    output logic      [WIDTH-1:0]  alt_in_o,
    input  wire logic [WIDTH-1:0]  alt_out_i,
    input  wire logic [WIDTH-1:0]  alt_oe_i,
    // Interrupt to controller
    output logic                   irq_o
);

    typedef struct packed {
        logic [WIDTH-1:0] sync1;
        logic [WIDTH-1:0] sync2;
        logic [WIDTH-1:0] prev;
        logic [WIDTH-1:0] out_val;
        logic [WIDTH-1:0] dir;
        logic [WIDTH-1:0] ien;
        logic [WIDTH-1:0] pol;
        logic [WIDTH-1:0] edg;
        logic [WIDTH-1:0] alt;
        logic [WIDTH-1:0] edge_hit;
    } state_t;

    state_t r, nxt;
    logic [WIDTH-1:0] level_ev;
    logic [WIDTH-1:0] edge_ev;
    logic [WIDTH-1:0] w;

    // ======================================================================
    // Per-line event detection
    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_line
            // Level event follows polarity
            assign level_ev[g] = r.pol[g] ? r.sync2[g] : ~r.sync2[g];
            // Edge event: 1 rising, 0 falling
            assign edge_ev[g]  = r.pol[g] ? (r.sync2[g] & ~r.prev[g])
                                          : (~r.sync2[g] & r.prev[g]);
            assign pin_out_o[g]  = r.alt[g] ? alt_out_i[g] : r.out_val[g];
            assign pin_oe_n_o[g] = r.alt[g] ? ~alt_oe_i[g] : ~r.dir[g];
        end
    endgenerate

    assign w         = wdata_i[WIDTH-1:0];
    assign alt_sel_o = r.alt;
    assign alt_in_o  = r.sync2;

    // ======================================================================
    // Next state
    always_comb begin
        nxt       = r;
        nxt.sync1 = pin_in_i;
        nxt.sync2 = r.sync1;
        nxt.prev  = r.sync2;
        // Writing 1 clears a held edge event; a new edge wins
        if (wr_i && sel_i == gpio_pkg::SEL_INPUT) begin
            nxt.edge_hit = r.edge_hit & ~w;
        end
        nxt.edge_hit = nxt.edge_hit | (edge_ev & r.edg);
        if (wr_i) begin
            case (sel_i)
                gpio_pkg::SEL_OUTPUT:     nxt.out_val = w;
                gpio_pkg::SEL_DIRECTION:  nxt.dir     = w;
                gpio_pkg::SEL_IRQ_ENABLE: nxt.ien     = w;
                gpio_pkg::SEL_POLARITY:   nxt.pol     = w;
                gpio_pkg::SEL_EDGE:       nxt.edg     = w;
                gpio_pkg::SEL_ALT:        nxt.alt     = w;
                default:                  ;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    // Level mode when edge bit is 0; gated by enable; OR over lines
    assign irq_o = |(r.ien & ((level_ev & ~r.edg) | (r.edge_hit & r.edg)));

    // ======================================================================
    // Read mux, unused upper bits read zero
    always_comb begin
        rdata_o = 32'h0000_0000;
        case (sel_i)
            gpio_pkg::SEL_INPUT:      rdata_o[WIDTH-1:0] = r.sync2;
            gpio_pkg::SEL_OUTPUT:     rdata_o[WIDTH-1:0] = r.out_val;
            gpio_pkg::SEL_DIRECTION:  rdata_o[WIDTH-1:0] = r.dir;
            gpio_pkg::SEL_IRQ_ENABLE: rdata_o[WIDTH-1:0] = r.ien;
            gpio_pkg::SEL_POLARITY:   rdata_o[WIDTH-1:0] = r.pol;
            gpio_pkg::SEL_EDGE:       rdata_o[WIDTH-1:0] = r.edg;
            gpio_pkg::SEL_ALT:        rdata_o[WIDTH-1:0] = r.alt;
            default:                  rdata_o = 32'h0000_0000;
        endcase
    end

    // ======================================================================
    // Checks
    property p_sync_delay;
        @(posedge clk_i) disable iff (!rst_n_i)
        1 |-> ##2 r.sync2 == $past(pin_in_i, 2);
    endproperty
    sync_two_flops_a: assert property (p_sync_delay)
        else $error("input synchroniser not two stages");

    drive_dir_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (r.alt == '0) |-> pin_oe_n_o == ~r.dir)
        else $error("output enable does not follow direction");

    drive_value_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (r.alt == '0) |-> pin_out_o == r.out_val)
        else $error("output value not driven from register");

    irq_mask_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        (r.ien == '0) |-> !irq_o)
        else $error("interrupt raised with all lines masked");

    sequence s_low_level;
        |(r.ien & ~r.edg & ~r.pol & ~r.sync2);
    endsequence
    level_low_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_low_level |-> irq_o)
        else $error("low level event not raised");

    // Rising edge on an enabled edge line; held event must show next cycle
    sequence s_rise;
        |(r.sync2 & ~r.prev & r.edg & r.pol & r.ien);
    endsequence
    edge_rise_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        s_rise |=> irq_o || ((r.edg & r.ien & $past(r.sync2 & ~r.prev & r.pol & r.edg)) == '0))
        else $error("rising edge event not held");

    generate
        if (WIDTH < 32) begin : g_narrow
            narrow_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
                rdata_o[31:WIDTH] == '0)
                else $error("unused bits read nonzero");
        end
    endgenerate

    alt_hand_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        r.alt[0] |-> pin_out_o[0] == alt_out_i[0])
        else $error("alternate function not given the pin");

endmodule : gpio_port

/* File: verilog/gpio_ports.sv */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`include "gpio_cfg.svh"
// Operation
// - Four ports of 32, 32, 24 and 16 lines, each line input or output.
// - Every pin input passes two system-clock flip-flops before use.
// - Input-value register reads the synchronised pin levels, one bit per line.
// - Direction bit 1 drives the line; 0 releases it.
// - Output lines drive the matching output-value register bit.
// - Register bit position equals line number.
// - A line's event interrupt needs its enable bit at 1.
// - Edge-select 0 means level detection.
// - Level mode with polarity 0 raises the event while input is low.
// - Edge-select 1 means transition detection on the synchronised input.
// - Alternate-function bit 1 hands the pin to its peripheral.
// - Unused upper bits of narrow ports read zero and ignore writes.
// - Ports sit 0x100 apart; address is base plus offset.
// - Each port drives its own interrupt, sources 35 to 38 in order.

module gpio_ports #(
    parameter int WA = `WIDTH_PORT_A,
    parameter int WB = `WIDTH_PORT_B,
    parameter int WC = `WIDTH_PORT_C,
    parameter int WD = `WIDTH_PORT_D
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_n_i,
    // Register port
    input  wire logic [11:0]   addr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output logic      [31:0]   rdata_o,
    // Port A pins
    input  wire logic [WA-1:0] a_pin_i,
    output logic      [WA-1:0] a_pin_o,
    output logic      [WA-1:0] a_pin_oe_n_o,
    output logic      [WA-1:0] a_alt_sel_o,
    output logic      [WA-1:0] a_alt_in_o,
    input  wire logic [WA-1:0] a_alt_out_i,
    input  wire logic [WA-1:0] a_alt_oe_i,
    // Port B pins
    input  wire logic [WB-1:0] b_pin_i,
    output logic      [WB-1:0] b_pin_o,
    output logic      [WB-1:0] b_pin_oe_n_o,
    output logic      [WB-1:0] b_alt_sel_o,
    output logic      [WB-1:0] b_alt_in_o,
    input  wire logic [WB-1:0] b_alt_out_i,
    input  wire logic [WB-1:0] b_alt_oe_i,
    // Port C pins
    input  wire logic [WC-1:0] c_pin_i,
    output logic      [WC-1:0] c_pin_o,
    output logic      [WC-1:0] c_pin_oe_n_o,
    output logic      [WC-1:0] c_alt_sel_o,
    output logic      [WC-1:0] c_alt_in_o,
    input  wire logic [WC-1:0] c_alt_out_i,
    input  wire logic [WC-1:0] c_alt_oe_i,
    // Port D pins
    input  wire logic [WD-1:0] d_pin_i,
    output logic      [WD-1:0] d_pin_o,
    output logic      [WD-1:0] d_pin_oe_n_o,
    output logic      [WD-1:0] d_alt_sel_o,
    output logic      [WD-1:0] d_alt_in_o,
    input  wire logic [WD-1:0] d_alt_out_i,
    input  wire logic [WD-1:0] d_alt_oe_i,
    // Interrupts, sources 35..38
    output logic      [3:0]    irq_o
);

    // ======================================================================
    // Reset release
    typedef struct packed {
        logic [1:0]  rst_sync;
        logic [31:0] rdata;
    } top_t;

    top_t r, nxt;
    logic rst_n;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= nxt;
        end
    end

    assign rst_n = r.rst_sync[1];

    // ======================================================================
    // Address decode
    logic [1:0]          port_idx;
    logic                base_ok;
    gpio_pkg::reg_sel_t  sel;
    logic [3:0]          wr_port;
    logic [31:0]         port_rd [4];

    assign port_idx = addr_i[9:8];
    assign base_ok  = (addr_i[11:10] == 2'(`PORT_A_BASE >> 10)) && (addr_i[1:0] == 2'h0);

    always_comb begin
        sel = gpio_pkg::SEL_NONE;
        if (base_ok) begin
            case (addr_i[7:0])
                `OFS_PIN_INPUT:    sel = gpio_pkg::SEL_INPUT;
                `OFS_PIN_OUTPUT:   sel = gpio_pkg::SEL_OUTPUT;
                `OFS_DIRECTION:    sel = gpio_pkg::SEL_DIRECTION;
                `OFS_IRQ_ENABLE:   sel = gpio_pkg::SEL_IRQ_ENABLE;
                `OFS_POLARITY:     sel = gpio_pkg::SEL_POLARITY;
                `OFS_EDGE_SELECT:  sel = gpio_pkg::SEL_EDGE;
                `OFS_ALT_FUNCTION: sel = gpio_pkg::SEL_ALT;
                default:           sel = gpio_pkg::SEL_NONE;
            endcase
        end
    end

    always_comb begin
        wr_port = 4'h0;
        if (wr_i && sel != gpio_pkg::SEL_NONE) begin
            wr_port[port_idx] = 1'b1;
        end
    end

    // ======================================================================
    // Ports, one bit per line in line order
    gpio_port #(.WIDTH(WA)) u_port_a (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .wr_i       (wr_port[0]),
        .sel_i      (sel),
        .wdata_i    (wdata_i),
        .rdata_o    (port_rd[0]),
        .pin_in_i   (a_pin_i),
        .pin_out_o  (a_pin_o),
        .pin_oe_n_o (a_pin_oe_n_o),
        .alt_sel_o  (a_alt_sel_o),
        .alt_in_o   (a_alt_in_o),
        .alt_out_i  (a_alt_out_i),
        .alt_oe_i   (a_alt_oe_i),
        .irq_o      (irq_o[0])
    );

    gpio_port #(.WIDTH(WB)) u_port_b (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .wr_i       (wr_port[1]),
        .sel_i      (sel),
        .wdata_i    (wdata_i),
        .rdata_o    (port_rd[1]),
        .pin_in_i   (b_pin_i),
        .pin_out_o  (b_pin_o),
        .pin_oe_n_o (b_pin_oe_n_o),
        .alt_sel_o  (b_alt_sel_o),
        .alt_in_o   (b_alt_in_o),
        .alt_out_i  (b_alt_out_i),
        .alt_oe_i   (b_alt_oe_i),
        .irq_o      (irq_o[1])
    );

    gpio_port #(.WIDTH(WC)) u_port_c (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .wr_i       (wr_port[2]),
        .sel_i      (sel),
        .wdata_i    (wdata_i),
        .rdata_o    (port_rd[2]),
        .pin_in_i   (c_pin_i),
        .pin_out_o  (c_pin_o),
        .pin_oe_n_o (c_pin_oe_n_o),
        .alt_sel_o  (c_alt_sel_o),
        .alt_in_o   (c_alt_in_o),
        .alt_out_i  (c_alt_out_i),
        .alt_oe_i   (c_alt_oe_i),
        .irq_o      (irq_o[2])
    );

    gpio_port #(.WIDTH(WD)) u_port_d (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n),
        .wr_i       (wr_port[3]),
        .sel_i      (sel),
        .wdata_i    (wdata_i),
        .rdata_o    (port_rd[3]),
        .pin_in_i   (d_pin_i),
        .pin_out_o  (d_pin_o),
        .pin_oe_n_o (d_pin_oe_n_o),
        .alt_sel_o  (d_alt_sel_o),
        .alt_in_o   (d_alt_in_o),
        .alt_out_i  (d_alt_out_i),
        .alt_oe_i   (d_alt_oe_i),
        .irq_o      (irq_o[3])
    );

    // ======================================================================
    // Next state: reset release and read data
    always_comb begin
        nxt          = r;
        nxt.rst_sync = {r.rst_sync[0], 1'b1};
        nxt.rdata    = 32'h0000_0000;
        if (rd_i && sel != gpio_pkg::SEL_NONE) begin
            nxt.rdata = port_rd[port_idx];
        end
    end

    assign rdata_o = r.rdata;

    // ======================================================================
    // Checks
    read_lag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (rd_i && sel == gpio_pkg::SEL_INPUT && port_idx == 2'h0)
        |=> rdata_o == $past(port_rd[0]))
        else $error("read data not returned one cycle later");

    idle_read_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        !rd_i |=> rdata_o == 32'h0000_0000)
        else $error("read data present without a read");

    port_d_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
        (rd_i && port_idx == 2'h3) |=> rdata_o[31:16] == 16'h0000)
        else $error("port d upper bits not zero");

endmodule : gpio_ports
